// file: core/aoc_pkg.sv
// shared constants and types for the offset cancellation control block
package aoc_pkg;
  localparam int CLK_MHZ = 100;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_IRQ = 8'h08;
  localparam logic [7:0] ADR_OFFW = 8'hC0;
  // field positions
  localparam int CTRL_PDOWN = 0;
  localparam int CTRL_INJ = 23;
  localparam int CTRL_NORM = 24;
  localparam int CTRL_CANCEL = 28;
  localparam int STAT_NORM = 24;
  localparam int STAT_CANCEL = 28;
  localparam int IRQ_OVER = 25;
  localparam int IRQ_ERR = 26;
  localparam int OFFW_LOAD = 15;
  localparam int OFFW_LO = 24;
  localparam int OFFW_W = 8;
  // converter state codes
  localparam logic [2:0] CODE_IDLE = 3'h0;
  localparam logic [2:0] CODE_PDOWN = 3'h1;
  localparam logic [2:0] CODE_CONV = 3'h2;
  // times and derived cycle counts
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  localparam int MEAS_TIMEOUT_NS = 10000;
  localparam int MEAS_TIMEOUT_CYC = (MEAS_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  // least sampling time software must program at this converter clock
  localparam int ADC_CLK_MHZ = 32;
  localparam int SAMPLE_MIN_NS = 180;
  typedef enum logic [2:0] {AOC_PDOWN, AOC_PWRUP, AOC_IDLE, AOC_CANCEL, AOC_CONV} aoc_state_t;
endpackage

// file: core/aoc_sync.sv
// two flip-flop synchroniser for pins from the analog core
module aoc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  if (W < 1) begin : g_bad
    $error("aoc_sync width must be at least one");
  end

  // first stage feeds the second only
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule // aoc_sync

// file: core/aoc_timer.sv
// restartable cycle timer with a one-cycle expiry pulse
module aoc_timer #(
  parameter int CYCLES = 100
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic run, // count while high
  input wire logic restart, // zero the count
  output logic expired // one-cycle pulse at the end
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_expired;

  if (CYCLES < 1) begin : g_bad
    $error("aoc_timer needs at least one cycle");
  end

  // count stops at the end; a stuck run then pulses every second cycle
  always_comb begin
    next_cnt = cnt;
    next_expired = 1'b0;
    if (restart || !run) begin
      next_cnt = '0;
    end else if (cnt == LAST) begin
      next_expired = 1'b1;
      next_cnt = cnt;
    end else begin
      next_cnt = cnt + CW'(1);
    end
    if (cnt == LAST && run && !restart && expired) begin
      next_expired = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule // aoc_timer

// file: core/aoc_ctrl.sv
// offset cancellation control with wishbone registers
// Behaviour
// (RL1) control bit 28 requests cancellation phase
// (RL2) hardware clears control enable when phase finishes
// (RL3) status bit 28 high while phase runs
// (RL4) state code 001 powered down, 000 idle
// (RL5) clearing power-down bit leads to idle code
// (RL6) on failure error flag, enables stay one
// (RL7) abort by control clear; status flag stays
// (RL8) software aborts, waits idle, clears error flag
// (RL9) offset word reserved bits read zero
// (RL10) bit 15 enables offset loading
// (RL11) offset field captures coefficient at phase end
// (RL12) software offset goes to core, overriding result
// (RL13) software offset reaches core through a conversion
// (RL14) software starts dummy conversion, polls status
// (RL15) software clears load bit after dummy conversion
// (RL16) interrupt bit 25 on offset completion
// (RL17) interrupt bit 26 when measurement pulse missing
// (RL18) both flags cleared by writing one
// (RL19) sampling time at least 180 ns
// (RL20) each set flag drives an interrupt line
module aoc_ctrl #(
  parameter int PWRUP_CYC = aoc_pkg::PWRUP_CYC,
  parameter int TIMEOUT_CYC = aoc_pkg::MEAS_TIMEOUT_CYC
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // async reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic core_offset_ok, // core: phase over
  input wire logic core_measure_ok, // core: measurement pulse
  input wire logic [7:0] core_coef, // core: computed coefficient
  input wire logic core_conv_done, // core: conversion finished
  output logic core_power_down, // core power-down level
  output logic core_cancel_run, // core: run cancellation
  output logic core_conv_req, // core: conversion request
  output logic [7:0] core_offset_word, // offset word to core
  output logic core_offset_load, // one-cycle load strobe
  output logic irq_phase_over, // phase-over request
  output logic irq_offset_error // offset error request
);
  localparam int PW_MAX = PWRUP_CYC + 3;

  if (PWRUP_CYC < 1 || TIMEOUT_CYC < 1) begin : g_bad
    $error("aoc_ctrl cycle counts must be at least one");
  end

  aoc_pkg::aoc_state_t state, next_state;
  logic ctrl_cancel, ctrl_pdown, ctrl_norm, ctrl_inj, stat_cancel;
  logic over_flag, err_flag, load_en;
  logic [7:0] offw;
  logic ok_d, meas_d, done_d;
  logic next_ctrl_cancel, next_ctrl_pdown, next_ctrl_norm, next_ctrl_inj, next_stat_cancel;
  logic next_over_flag, next_err_flag, next_load_en;
  logic [7:0] next_offw, next_core_word;
  logic next_ack, next_conv_req, next_core_load, next_cancel_run, next_pwr;
  logic [31:0] next_dat, wmask, rd_word;
  logic ok_s, meas_s, done_s;
  logic [7:0] coef_s;
  logic ok_rise, meas_rise, done_rise, pw_exp, meas_exp, req, wr;

  // byte lanes into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // converter state code seen by software
  function automatic logic [2:0] state_code(input aoc_pkg::aoc_state_t s);
    case (s)
      aoc_pkg::AOC_PDOWN, aoc_pkg::AOC_PWRUP: state_code = aoc_pkg::CODE_PDOWN;
      aoc_pkg::AOC_CONV: state_code = aoc_pkg::CODE_CONV;
      default: state_code = aoc_pkg::CODE_IDLE;
    endcase
  endfunction

  aoc_sync #(.W(3)) u_sync_bits (
    .clk(clk),
    .rst(rst),
    .d({core_offset_ok, core_measure_ok, core_conv_done}),
    .q({ok_s, meas_s, done_s})
  );

  // coefficient is steady while offset_ok rises, so per-bit sync is safe
  aoc_sync #(.W(8)) u_sync_coef (
    .clk(clk),
    .rst(rst),
    .d(core_coef),
    .q(coef_s)
  );

  // settle time after leaving power-down
  aoc_timer #(.CYCLES(PWRUP_CYC)) u_pwrup (
    .clk(clk),
    .rst(rst),
    .run(state == aoc_pkg::AOC_PWRUP),
    .restart(state != aoc_pkg::AOC_PWRUP),
    .expired(pw_exp)
  );

  // watchdog on measurement pulses during the phase
  aoc_timer #(.CYCLES(TIMEOUT_CYC)) u_meas ( // RL17
    .clk(clk),
    .rst(rst),
    .run(state == aoc_pkg::AOC_CANCEL),
    .restart(meas_rise || state != aoc_pkg::AOC_CANCEL),
    .expired(meas_exp)
  );

  // edges and bus qualifiers
  assign ok_rise = ok_s && !ok_d; // RL16
  assign meas_rise = meas_s && !meas_d;
  assign done_rise = done_s && !done_d;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  assign wmask = lane_mask(wb_sel_i);
  assign irq_phase_over = over_flag; // RL20
  assign irq_offset_error = err_flag; // RL20

  // read mux; reserved bits stay zero
  always_comb begin
    rd_word = '0;
    case (wb_adr_i)
      aoc_pkg::ADR_CTRL: begin
        rd_word[aoc_pkg::CTRL_PDOWN] = ctrl_pdown;
        rd_word[aoc_pkg::CTRL_INJ] = ctrl_inj;
        rd_word[aoc_pkg::CTRL_NORM] = ctrl_norm;
        rd_word[aoc_pkg::CTRL_CANCEL] = ctrl_cancel;
      end
      aoc_pkg::ADR_STAT: begin
        rd_word[2:0] = state_code(state); // RL4
        rd_word[aoc_pkg::STAT_NORM] = (state == aoc_pkg::AOC_CONV);
        rd_word[aoc_pkg::STAT_CANCEL] = stat_cancel; // RL3
      end
      aoc_pkg::ADR_IRQ: begin
        rd_word[aoc_pkg::IRQ_OVER] = over_flag;
        rd_word[aoc_pkg::IRQ_ERR] = err_flag;
      end
      aoc_pkg::ADR_OFFW: begin
        rd_word[aoc_pkg::OFFW_LOAD] = load_en; // RL9
        rd_word[aoc_pkg::OFFW_LO +: aoc_pkg::OFFW_W] = offw;
      end
      default: rd_word = '0;
    endcase
  end

  // register writes first, then hardware events so hardware wins over same-cycle writes
  always_comb begin
    next_state = state;
    next_ctrl_cancel = ctrl_cancel;
    next_ctrl_pdown = ctrl_pdown;
    next_ctrl_norm = ctrl_norm;
    next_ctrl_inj = ctrl_inj;
    next_stat_cancel = stat_cancel;
    next_over_flag = over_flag;
    next_err_flag = err_flag;
    next_load_en = load_en;
    next_offw = offw;
    next_core_word = core_offset_word;
    next_conv_req = core_conv_req;
    next_core_load = 1'b0;
    next_ack = req;
    next_dat = req ? rd_word : '0;
    if (wr && wb_adr_i == aoc_pkg::ADR_CTRL) begin
      if (wmask[aoc_pkg::CTRL_PDOWN]) next_ctrl_pdown = wb_dat_i[aoc_pkg::CTRL_PDOWN];
      if (wmask[aoc_pkg::CTRL_INJ]) next_ctrl_inj = wb_dat_i[aoc_pkg::CTRL_INJ];
      if (wmask[aoc_pkg::CTRL_NORM]) next_ctrl_norm = wb_dat_i[aoc_pkg::CTRL_NORM];
      if (wmask[aoc_pkg::CTRL_CANCEL]) next_ctrl_cancel = wb_dat_i[aoc_pkg::CTRL_CANCEL]; // RL1 RL7
    end
    if (wr && wb_adr_i == aoc_pkg::ADR_IRQ) begin
      if (wmask[aoc_pkg::IRQ_OVER] && wb_dat_i[aoc_pkg::IRQ_OVER]) next_over_flag = 1'b0; // RL18
      if (wmask[aoc_pkg::IRQ_ERR] && wb_dat_i[aoc_pkg::IRQ_ERR]) next_err_flag = 1'b0; // RL18
    end
    if (wr && wb_adr_i == aoc_pkg::ADR_OFFW && wmask[aoc_pkg::OFFW_LOAD]) begin
      next_load_en = wb_dat_i[aoc_pkg::OFFW_LOAD]; // RL10
      // field only taken when the same write keeps loading enabled
      if (wb_dat_i[aoc_pkg::OFFW_LOAD] && wmask[aoc_pkg::OFFW_LO]) begin
        next_offw = wb_dat_i[aoc_pkg::OFFW_LO +: aoc_pkg::OFFW_W]; // RL10 RL12
      end
    end
    // sequencer
    case (state)
      aoc_pkg::AOC_PDOWN: begin
        if (!ctrl_pdown) next_state = aoc_pkg::AOC_PWRUP; // RL5
      end
      aoc_pkg::AOC_PWRUP: begin
        if (pw_exp) begin
          if (ctrl_cancel) begin
            next_state = aoc_pkg::AOC_CANCEL; // RL1
            next_stat_cancel = 1'b1; // RL3
          end else begin
            next_state = aoc_pkg::AOC_IDLE; // RL5
          end
        end
      end
      aoc_pkg::AOC_IDLE: begin
        if (ctrl_norm || ctrl_inj) begin
          next_state = aoc_pkg::AOC_CONV;
          next_conv_req = 1'b1;
          next_ctrl_norm = 1'b0;
          next_ctrl_inj = 1'b0;
          // buffered core offset only moves at a conversion start
          if (load_en) begin
            next_core_word = offw; // RL13
            next_core_load = 1'b1; // RL12
          end
        end
      end
      aoc_pkg::AOC_CANCEL: begin
        if (ok_rise) begin
          if (!load_en) next_offw = coef_s; // RL11 RL12
          next_over_flag = 1'b1; // RL16
          next_ctrl_cancel = 1'b0; // RL2
          next_stat_cancel = 1'b0; // RL3
          next_state = aoc_pkg::AOC_IDLE;
        end else if (meas_exp) begin
          next_err_flag = 1'b1; // RL6 RL17
          next_state = aoc_pkg::AOC_IDLE;
        end else if (!ctrl_cancel) begin
          next_state = aoc_pkg::AOC_IDLE; // RL7
        end
      end
      aoc_pkg::AOC_CONV: begin
        if (done_rise) begin
          next_conv_req = 1'b0;
          next_state = aoc_pkg::AOC_IDLE;
        end
      end
      default: next_state = aoc_pkg::AOC_PDOWN;
    endcase
    // power-down overrides the next state and any conversion request
    if (ctrl_pdown) begin
      next_state = aoc_pkg::AOC_PDOWN; // RL4
      next_conv_req = 1'b0;
    end
    next_cancel_run = (next_state == aoc_pkg::AOC_CANCEL);
    next_pwr = (next_state == aoc_pkg::AOC_PDOWN);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= aoc_pkg::AOC_PDOWN;
      ctrl_cancel <= 1'b0;
      ctrl_pdown <= 1'b1;
      ctrl_norm <= 1'b0;
      ctrl_inj <= 1'b0;
      stat_cancel <= 1'b0;
      over_flag <= 1'b0;
      err_flag <= 1'b0;
      load_en <= 1'b0;
      offw <= '0;
      ok_d <= 1'b0;
      meas_d <= 1'b0;
      done_d <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      core_power_down <= 1'b1;
      core_cancel_run <= 1'b0;
      core_conv_req <= 1'b0;
      core_offset_word <= '0;
      core_offset_load <= 1'b0;
    end else begin
      state <= next_state;
      ctrl_cancel <= next_ctrl_cancel;
      ctrl_pdown <= next_ctrl_pdown;
      ctrl_norm <= next_ctrl_norm;
      ctrl_inj <= next_ctrl_inj;
      stat_cancel <= next_stat_cancel;
      over_flag <= next_over_flag;
      err_flag <= next_err_flag;
      load_en <= next_load_en;
      offw <= next_offw;
      ok_d <= ok_s;
      meas_d <= meas_s;
      done_d <= done_s;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      core_power_down <= next_pwr;
      core_cancel_run <= next_cancel_run;
      core_conv_req <= next_conv_req;
      core_offset_word <= next_core_word;
      core_offset_load <= next_core_load;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  phase_clear_a: assert property (state == aoc_pkg::AOC_CANCEL && ok_rise && !ctrl_pdown // RL2
    |=> !ctrl_cancel && !stat_cancel && over_flag && state == aoc_pkg::AOC_IDLE)
    else $error("phase end did not clear enables");
  stat_busy_a: assert property (state == aoc_pkg::AOC_CANCEL |-> stat_cancel) // RL3
    else $error("status cancel flag low during phase");
  pdown_code_a: assert property (ctrl_pdown |=> core_power_down && state_code(state) == aoc_pkg::CODE_PDOWN) // RL4
    else $error("power-down not reported");
  pwrup_idle_a: assert property ($fell(ctrl_pdown) && !ctrl_cancel // RL5
    |-> ##[1:PW_MAX] state_code(state) == aoc_pkg::CODE_IDLE)
    else $error("idle code not reached after power-up");
  err_keep_a: assert property ($rose(err_flag) |-> ctrl_cancel && stat_cancel) // RL6
    else $error("enables lost on error");
  abort_sticky_a: assert property (stat_cancel && state != aoc_pkg::AOC_CANCEL |=> stat_cancel) // RL7
    else $error("status cancel flag dropped outside phase");
  resv_zero_a: assert property (wb_ack_o && wb_adr_i == aoc_pkg::ADR_OFFW // RL9
    |-> wb_dat_o[14:0] == 15'h0000 && wb_dat_o[23:16] == 8'h00)
    else $error("reserved offset bits not zero");
  coef_latch_a: assert property (state == aoc_pkg::AOC_CANCEL && ok_rise && !load_en && !ctrl_pdown // RL11
    |=> offw == $past(coef_s))
    else $error("coefficient not latched");
  load_pass_a: assert property (state == aoc_pkg::AOC_IDLE && (ctrl_norm || ctrl_inj) && load_en && !ctrl_pdown // RL13
    |=> core_offset_load && core_offset_word == $past(offw) ##1 !core_offset_load)
    else $error("software offset not passed to core");
  meas_err_a: assert property (state == aoc_pkg::AOC_CANCEL && meas_exp && !ok_rise && !ctrl_pdown // RL17
    |=> err_flag)
    else $error("missing measurement not flagged");
  w1c_over_a: assert property (wr && wb_adr_i == aoc_pkg::ADR_IRQ && wb_sel_i[3] && wb_dat_i[aoc_pkg::IRQ_OVER] // RL18
    && !(state == aoc_pkg::AOC_CANCEL && ok_rise) |=> !over_flag)
    else $error("write one did not clear phase-over");
  w1c_err_a: assert property (wr && wb_adr_i == aoc_pkg::ADR_IRQ && wb_sel_i[3] && wb_dat_i[aoc_pkg::IRQ_ERR] // RL18
    && !(state == aoc_pkg::AOC_CANCEL && meas_exp && !ok_rise) |=> !err_flag)
    else $error("write one did not clear offset error");
  abort_idle_a: assert property (state == aoc_pkg::AOC_CANCEL && !ctrl_cancel && !ok_rise && !meas_exp // RL7
    |=> state != aoc_pkg::AOC_CANCEL && stat_cancel && !core_cancel_run)
    else $error("abort left the phase running");
  start_clear_a: assert property (state == aoc_pkg::AOC_IDLE && (ctrl_norm || ctrl_inj) && !ctrl_pdown // RL13
    |=> state == aoc_pkg::AOC_CONV && core_conv_req && !ctrl_norm && !ctrl_inj)
    else $error("conversion start not taken");
  pdown_stop_a: assert property (ctrl_pdown |=> !core_conv_req && !core_cancel_run) // RL4
    else $error("activity kept in power-down");

  phase_ok_c: cover property (state == aoc_pkg::AOC_CANCEL ##1 over_flag && state == aoc_pkg::AOC_IDLE);
  phase_err_c: cover property ($rose(err_flag));
  conv_load_c: cover property (core_offset_load ##[1:50] !core_conv_req);
  abort_c: cover property (state == aoc_pkg::AOC_CANCEL && !ctrl_cancel && !ok_rise && !meas_exp);
endmodule // aoc_ctrl

// file: tb/aoc_core_model.sv
// behavioural model of the analog converter core facing the control block
module aoc_core_model (
  input wire logic clk, // system clock
  input wire logic cancel_run, // phase request from control
  input wire logic conv_req, // conversion request from control
  input wire logic [7:0] offset_word, // offset word from control
  input wire logic offset_load, // load strobe from control
  input wire logic fail_mode, // withhold measurement pulses
  input wire logic [7:0] coef_val, // coefficient to report
  output logic offset_ok, // phase over
  output logic measure_ok, // measurement pulse
  output logic [7:0] coef, // computed coefficient
  output logic conv_done, // conversion finished
  output logic [7:0] loaded_word, // last word taken by the core
  output int load_count // number of load strobes seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // a conversion samples for no less than the least sampling time
  localparam int SAMPLE_CYC = (aoc_pkg::SAMPLE_MIN_NS * aoc_pkg::CLK_MHZ + 999) / 1000;
  // cancellation phase: one measurement pulse, phase over 7 cycles later, well inside the timeout
  initial begin
    offset_ok = 1'b0;
    measure_ok = 1'b0;
    coef = 8'h00;
    forever begin
      @(posedge clk iff cancel_run === 1'b1);
      if (fail_mode !== 1'b1) begin
        repeat (4) @(posedge clk);
        measure_ok <= 1'b1;
        coef <= coef_val;
        @(posedge clk);
        measure_ok <= 1'b0;
        repeat (6) @(posedge clk);
        offset_ok <= 1'b1;
        wait (cancel_run !== 1'b1);
        // coefficient must hold a few cycles past the rise
        repeat (4) @(posedge clk);
        offset_ok <= 1'b0;
        coef <= ~coef_val;
      end else begin
        wait (cancel_run !== 1'b1);
      end
    end
  end
  // a conversion lasts the sampling time, done drops once request falls
  initial begin
    conv_done = 1'b0;
    forever begin
      @(posedge clk iff conv_req === 1'b1);
      repeat (SAMPLE_CYC) @(posedge clk);
      conv_done <= 1'b1;
      wait (conv_req !== 1'b1);
      @(posedge clk);
      conv_done <= 1'b0;
    end
  end
  // record what the control block hands over
  initial begin
    loaded_word = 8'h00;
    load_count = 0;
    forever begin
      @(posedge clk);
      if (offset_load === 1'b1) begin
        loaded_word <= offset_word;
        load_count <= load_count + 1;
      end
    end
  end
endmodule // aoc_core_model

// file: tb/adc_offset_cancel_ctrl_tb_top.sv
// self-checking bench for the offset cancellation control block
module adc_offset_cancel_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic ok, meas, cdone, pdown, crun, creq, oload, irq_over, irq_err;
  logic [7:0] coef, oword, loaded_word;
  logic fail_mode = 1'b0;
  int load_count;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rdata;

  always #5 clk = ~clk;

  aoc_ctrl #(.PWRUP_CYC(4), .TIMEOUT_CYC(20)) u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .core_offset_ok(ok), .core_measure_ok(meas), .core_coef(coef), .core_conv_done(cdone),
    .core_power_down(pdown), .core_cancel_run(crun), .core_conv_req(creq), .core_offset_word(oword),
    .core_offset_load(oload), .irq_phase_over(irq_over), .irq_offset_error(irq_err));

  aoc_core_model u_core (.clk(clk), .cancel_run(crun), .conv_req(creq), .offset_word(oword),
    .offset_load(oload), .fail_mode(fail_mode), .coef_val(8'h5A), .offset_ok(ok), .measure_ok(meas),
    .coef(coef), .conv_done(cdone), .loaded_word(loaded_word), .load_count(load_count));

  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, generous against the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("[FAIL] run length expected below 20000 seen %0d", cycles);
      wrap_up();
    end
  end

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_i <= d;
    // no local limit: only the hang guard ends a stuck wait
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rdata = dat_o;
    chk_word("bus ack wait", 32'h0000_0002, 32'(n));
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    dat_i <= ~d; // released data does not keep the old value
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // read until one bit reaches a value, bounded
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (rdata[b] !== v && n < 300);
    chk_bit("polled bit", v, rdata[b]);
  endtask

  task automatic t_reset();
    chk_bit("power down pin", 1'b1, pdown);
    rd(aoc_pkg::ADR_CTRL);
    chk_word("control reset", 32'h0000_0001, rdata);
    rd(aoc_pkg::ADR_STAT);
    chk_word("status reset", 32'h0000_0001, rdata);
    rd(aoc_pkg::ADR_OFFW);
    chk_word("offset word reset", 32'h0000_0000, rdata);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10);
    chk_word("unmapped read", 32'h0000_0000, rdata);
  endtask

  task automatic t_cancel_ok();
    wr(aoc_pkg::ADR_CTRL, 32'h1000_0001);
    wr(aoc_pkg::ADR_CTRL, 32'h1000_0000);
    poll(aoc_pkg::ADR_STAT, aoc_pkg::STAT_CANCEL, 1'b1);
    poll(aoc_pkg::ADR_STAT, aoc_pkg::STAT_CANCEL, 1'b0);
    rd(aoc_pkg::ADR_CTRL);
    chk_word("control after phase", 32'h0000_0000, rdata);
    rd(aoc_pkg::ADR_STAT);
    chk_word("status idle", 32'h0000_0000, rdata);
    rd(aoc_pkg::ADR_IRQ);
    chk_word("phase over flag", 32'h0200_0000, rdata);
    chk_bit("phase over line", 1'b1, irq_over);
    rd(aoc_pkg::ADR_OFFW);
    chk_word("latched coefficient", 32'h5A00_0000, rdata);
    wr(aoc_pkg::ADR_IRQ, 32'h0000_0000);
    rd(aoc_pkg::ADR_IRQ);
    chk_word("flag after zero write", 32'h0200_0000, rdata);
    wr(aoc_pkg::ADR_IRQ, 32'h0200_0000);
    rd(aoc_pkg::ADR_IRQ);
    chk_word("flag after one write", 32'h0000_0000, rdata);
  endtask

  task automatic t_cancel_fail();
    fail_mode = 1'b1;
    wr(aoc_pkg::ADR_CTRL, 32'h1000_0001);
    rd(aoc_pkg::ADR_STAT);
    chk_word("state powered down", {29'h0, aoc_pkg::CODE_PDOWN}, {29'h0, rdata[2:0]});
    wr(aoc_pkg::ADR_CTRL, 32'h1000_0000);
    poll(aoc_pkg::ADR_IRQ, aoc_pkg::IRQ_ERR, 1'b1);
    chk_bit("error line", 1'b1, irq_err);
    rd(aoc_pkg::ADR_CTRL);
    chk_bit("control enable kept", 1'b1, rdata[aoc_pkg::CTRL_CANCEL]);
    rd(aoc_pkg::ADR_STAT);
    chk_bit("status enable kept", 1'b1, rdata[aoc_pkg::STAT_CANCEL]);
    wr(aoc_pkg::ADR_CTRL, 32'h0000_0000);
    poll(aoc_pkg::ADR_STAT, 0, 1'b0);
    chk_word("status after abort", 32'h1000_0000, rdata);
    wr(aoc_pkg::ADR_IRQ, 32'h0400_0000);
    rd(aoc_pkg::ADR_IRQ);
    chk_word("error flag cleared", 32'h0000_0000, rdata);
    fail_mode = 1'b0;
  endtask

  // reset mid-run clears the sticky status flag, then a plain power-up and a mid-phase abort
  task automatic t_abort_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_bit("power down pin after reset", 1'b1, pdown);
    rd(aoc_pkg::ADR_STAT);
    chk_word("status after reset", 32'h0000_0001, rdata);
    wr(aoc_pkg::ADR_CTRL, 32'h0000_0000);
    poll(aoc_pkg::ADR_STAT, 0, 1'b0);
    fail_mode = 1'b1;
    wr(aoc_pkg::ADR_CTRL, 32'h1000_0001);
    wr(aoc_pkg::ADR_CTRL, 32'h1000_0000);
    poll(aoc_pkg::ADR_STAT, aoc_pkg::STAT_CANCEL, 1'b1);
    chk_bit("cancel run pin", 1'b1, crun);
    wr(aoc_pkg::ADR_CTRL, 32'h0000_0000);
    // long enough for the watchdog to fire had the abort been missed
    repeat (30) @(posedge clk);
    chk_bit("cancel run after abort", 1'b0, crun);
    rd(aoc_pkg::ADR_STAT);
    chk_word("status after mid-phase abort", 32'h1000_0000, rdata);
    rd(aoc_pkg::ADR_IRQ);
    chk_word("no error after abort", 32'h0000_0000, rdata);
    fail_mode = 1'b0;
  endtask

  task automatic t_offset_load();
    int cnt;
    int b;
    wr(aoc_pkg::ADR_OFFW, 32'h3CFF_FFFF);
    rd(aoc_pkg::ADR_OFFW);
    chk_word("offset word written", 32'h3C00_8000, rdata);
    // both start bits with loading enabled, then a normal start with loading disabled
    for (int i = 0; i < 3; i++) begin
      b = (i == 1) ? aoc_pkg::CTRL_INJ : aoc_pkg::CTRL_NORM;
      if (i == 2) begin
        wr(aoc_pkg::ADR_OFFW, 32'h0000_0000);
        rd(aoc_pkg::ADR_OFFW);
        chk_word("load disabled", 32'h3C00_0000, rdata);
      end
      cnt = load_count;
      wr(aoc_pkg::ADR_CTRL, 32'h0000_0001 << b);
      poll(aoc_pkg::ADR_STAT, aoc_pkg::STAT_NORM, 1'b0);
      chk_word("load strobes", 32'(cnt + ((i < 2) ? 1 : 0)), 32'(load_count));
      chk_word("word at core", 32'h0000_003C, {24'h0, loaded_word});
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_cancel_ok();
    t_cancel_fail();
    t_abort_reset();
    t_offset_load();
    wrap_up();
  end
endmodule // adc_offset_cancel_ctrl_tb_top
